// file: common/freeze_params.svh
/*
  Constants for the freeze sequencer: register offsets, field
  positions, reset values and timing counts.
  Assumes a 20 MHz hclk; included by the package user files.
*/
`ifndef FREEZE_PARAMS_SVH
`define FREEZE_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_HOLD_IN   8'h04
`define OFS_HOLD_OUT  8'h08
`define OFS_PULL_EN   8'h0C
`define OFS_PULL_UP   8'h10
`define OFS_STATUS    8'h14

// Control fields
`define CTRL_TYPE2    0
`define CTRL_RST      32'h0000_0000

// Status fields
`define ST_FROZEN     0
`define ST_ENTERING   1
`define ST_EXITING    2
`define ST_PLL_OFF    3
`define ST_JTAG_BLK   4
`define ST_REQ_PIN    5
`define ST_CONFIRM    6
`define ST_POWERED    7

// Timing, in ns as specified, and derived cycle counts
`define CLK_PERIOD_NS 50
`define ENTRY_MAX_NS  1000
`define EXIT_MAX_NS   1000
`define PWRUP_MAX_NS  5000
`define ENTRY_MAX_CYC (`ENTRY_MAX_NS / `CLK_PERIOD_NS)
`define EXIT_MAX_CYC  (`EXIT_MAX_NS / `CLK_PERIOD_NS)
`define PWRUP_MAX_CYC (`PWRUP_MAX_NS / `CLK_PERIOD_NS)
// Settle stage uses half the budget, leaving margin for detection
`define ENTER_SETTLE  (`ENTRY_MAX_CYC / 2)
`define EXIT_SETTLE   (`EXIT_MAX_CYC / 2)

`endif

// file: common/freeze_pkg.sv
/*
  Types shared by the freeze sequencer files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package freeze_pkg;

  typedef enum logic [4:0] {
    ST_PWRUP  = 5'h01,
    ST_RUN    = 5'h02,
    ST_ENTER  = 5'h04,
    ST_FROZEN = 5'h08,
    ST_EXIT   = 5'h10
  } state_t;

endpackage

// file: rtl/freeze_timer.sv
/*
  Down counter for settle stages: load on start, one-cycle done.
  Assumes the single hclk domain and active-low async reset.
*/
`timescale 1ns/100ps
module freeze_timer #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Control
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  input  wire logic         abort,
  // Status
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy  <= 1'b0;
        cnt_q <= '0;
      end else if (start) begin
        busy  <= 1'b1;
        cnt_q <= load;
      end else if (busy) begin
        if (cnt_q <= W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_q <= cnt_q - W'(1);
      end
    end
  end

endmodule // freeze_timer

// file: rtl/freeze_io_cell.sv
/*
  One I/O site: core-side input forcing or hold, and pad state
  while frozen. Assumes capture pulses one cycle before forcing.
*/
`timescale 1ns/100ps
module freeze_io_cell (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Sequencer
  input  wire logic capture,
  input  wire logic force_in,
  input  wire logic pad_freeze,
  // Configuration
  input  wire logic hold_in,
  input  wire logic hold_out,
  input  wire logic pull_en,
  input  wire logic pull_up,
  // Pad side
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pull_en,
  output logic      pad_pull_up,
  // Core side
  input  wire logic core_out,
  input  wire logic core_oe,
  output logic      core_in
);

  logic in_held_q;
  logic out_held_q;

  // Last valid values before entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_held_q  <= 1'b0;
      out_held_q <= 1'b0;
    end else if (capture) begin
      in_held_q  <= pad_in;
      out_held_q <= core_out;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_in <= 1'b1;
    end else if (force_in) begin
      core_in <= hold_in ? in_held_q : 1'b1;
    end else begin
      core_in <= pad_in;
    end
  end

  // Freeze drops the driver; hold becomes a weak pull to held value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out     <= 1'b0;
      pad_oe      <= 1'b0;
      pad_pull_en <= 1'b0;
      pad_pull_up <= 1'b0;
    end else if (pad_freeze) begin
      pad_out     <= 1'b0;
      pad_oe      <= 1'b0;
      pad_pull_en <= hold_out | pull_en;
      pad_pull_up <= hold_out ? out_held_q : pull_up;
    end else begin
      // Follows the core signal one cycle later through a flop: a glitch between edges does not reach the pad
      pad_out     <= core_out;
      pad_oe      <= core_oe;
      pad_pull_en <= pull_en;
      pad_pull_up <= pull_up;
    end
  end

endmodule // freeze_io_cell

// file: rtl/freeze_ctrl.sv
/*
  Freeze-mode sequencer with AHB-Lite register slave, per-pin
  freeze cells, PLL power control and boundary-scan blocking.
  Assumes request pin, confirm and supply flag synchronous to hclk.
*/
// The address map and the AHB-Lite register port were decided locally.
// Contract
// - Power-up with entry condition true enters freeze within 5 us.
// - Type 1: freeze entry completes within 1 us of request pin.
// - Type 2: entry completes within 1 us of request and confirm.
// - Exit completes within 1 us of request deassert, confirm ignored.
// - Entering freeze powers down the PLL, kept off while frozen.
// - PLL clocks stop and pads freeze within 1 us of entry condition.
// - Inputs, globals and PLL freeze independently, no mutual ordering.
// - On entry core-side inputs and globals forced High, except hold.
// - Frozen outputs tristate unless pulled; core input value High.
// - While frozen boundary-scan commands are refused until exit.
// - On exit forcing released independently, except held inputs; code releases held inputs with the rest when exit starts.
// - Output hold release follows the output signal directly.
// - Held inputs keep last valid pad value before entry; code captures only on entry from run, not on entry from power-up.
`timescale 1ns/100ps
`include "freeze_params.svh"
module freeze_ctrl #(
  parameter int N_IO = 8,
  parameter int N_GL = 2,
  parameter int TW   = 8
) (
  // Clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // AHB-Lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  // Power and freeze control
  input  wire logic            supply_ok,
  input  wire logic            freeze_request_pin,
  input  wire logic            freeze_confirm_signal,
  // PLL and boundary scan
  output logic                 pll_power_down,
  output logic                 pll_clk_en,
  output logic                 jtag_block,
  output logic                 frozen,
  // Pads
  input  wire logic [N_IO-1:0] pad_in,
  output logic [N_IO-1:0]      pad_out,
  output logic [N_IO-1:0]      pad_oe,
  output logic [N_IO-1:0]      pad_pull_en,
  output logic [N_IO-1:0]      pad_pull_up,
  // Core
  input  wire logic [N_IO-1:0] core_out,
  input  wire logic [N_IO-1:0] core_oe,
  output logic [N_IO-1:0]      core_in,
  // Global networks
  input  wire logic [N_GL-1:0] glob_pad,
  output logic [N_GL-1:0]      glob_core
);

  //////////////////////////////////////////////////////////////////////////
  // Registers

  logic            type2_q;
  logic [N_IO-1:0] hold_in_q;
  logic [N_IO-1:0] hold_out_q;
  logic [N_IO-1:0] pull_en_q;
  logic [N_IO-1:0] pull_up_q;

  logic            wr_pend_q;
  logic [7:0]      wr_addr_q;
  logic [31:0]     status;
  logic [31:0]     rd_d;
  logic            acc;

  freeze_pkg::state_t state_q;
  freeze_pkg::state_t state_d;

  logic entry_cond;
  logic go_enter;
  logic go_exit;
  logic tmr_start;
  logic tmr_abort;
  logic [TW-1:0] tmr_load;
  logic tmr_done;

  logic force_in_q;
  logic force_gl_q;
  logic pad_freeze_q;
  logic capture;

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= acc & hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      type2_q <= 1'(`CTRL_RST);
    end else if (wr_pend_q && wr_addr_q == `OFS_CTRL) begin
      type2_q <= hwdata[`CTRL_TYPE2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_in_q  <= '0;
      hold_out_q <= '0;
      pull_en_q  <= '0;
      pull_up_q  <= '0;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        `OFS_HOLD_IN:  hold_in_q  <= hwdata[N_IO-1:0];
        `OFS_HOLD_OUT: hold_out_q <= hwdata[N_IO-1:0];
        `OFS_PULL_EN:  pull_en_q  <= hwdata[N_IO-1:0];
        `OFS_PULL_UP:  pull_up_q  <= hwdata[N_IO-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    status                = '0;
    status[`ST_FROZEN]    = frozen;
    status[`ST_ENTERING]  = (state_q == freeze_pkg::ST_ENTER);
    status[`ST_EXITING]   = (state_q == freeze_pkg::ST_EXIT);
    status[`ST_PLL_OFF]   = pll_power_down;
    status[`ST_JTAG_BLK]  = jtag_block;
    status[`ST_REQ_PIN]   = freeze_request_pin;
    status[`ST_CONFIRM]   = freeze_confirm_signal;
    status[`ST_POWERED]   = (state_q != freeze_pkg::ST_PWRUP);
  end

  // Unmapped offsets read as zero
  always_comb begin
    rd_d = '0;
    unique case (haddr[7:0])
      `OFS_CTRL:     rd_d[`CTRL_TYPE2] = type2_q;
      `OFS_HOLD_IN:  rd_d[N_IO-1:0]    = hold_in_q;
      `OFS_HOLD_OUT: rd_d[N_IO-1:0]    = hold_out_q;
      `OFS_PULL_EN:  rd_d[N_IO-1:0]    = pull_en_q;
      `OFS_PULL_UP:  rd_d[N_IO-1:0]    = pull_up_q;
      `OFS_STATUS:   rd_d              = status;
      default:       rd_d              = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Type 2 also needs the confirm; exit looks at the pin only
  assign entry_cond = freeze_request_pin &
                      (!type2_q | freeze_confirm_signal);
  assign go_enter   = (state_q == freeze_pkg::ST_RUN) & entry_cond;
  assign go_exit    = ((state_q == freeze_pkg::ST_ENTER) |
                       (state_q == freeze_pkg::ST_FROZEN)) &
                      !freeze_request_pin;
  assign capture    = go_enter;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      freeze_pkg::ST_PWRUP: begin
        // Condition already true at power-up enters at once
        if (supply_ok) begin
          state_d = entry_cond ? freeze_pkg::ST_ENTER
                               : freeze_pkg::ST_RUN;
        end
      end
      freeze_pkg::ST_RUN: begin
        if (entry_cond) begin
          state_d = freeze_pkg::ST_ENTER;
        end
      end
      freeze_pkg::ST_ENTER: begin
        if (go_exit) begin
          state_d = freeze_pkg::ST_EXIT;
        end else if (type2_q && !freeze_confirm_signal) begin
          // Confirm lost during entry: entry is abandoned
          state_d = freeze_pkg::ST_EXIT;
        end else if (tmr_done) begin
          state_d = freeze_pkg::ST_FROZEN;
        end
      end
      freeze_pkg::ST_FROZEN: begin
        if (go_exit) begin
          state_d = freeze_pkg::ST_EXIT;
        end
      end
      freeze_pkg::ST_EXIT: begin
        if (tmr_done) begin
          state_d = freeze_pkg::ST_RUN;
        end
      end
      default: state_d = freeze_pkg::ST_PWRUP;
    endcase
    if (!supply_ok) begin
      state_d = freeze_pkg::ST_PWRUP;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= freeze_pkg::ST_PWRUP;
    end else begin
      state_q <= state_d;
    end
  end

  assign tmr_start = (state_d != state_q) &
                     ((state_d == freeze_pkg::ST_ENTER) |
                      (state_d == freeze_pkg::ST_EXIT));
  assign tmr_abort = !supply_ok;
  assign tmr_load  = (state_d == freeze_pkg::ST_ENTER)
                     ? TW'(`ENTER_SETTLE)
                     : TW'(`EXIT_SETTLE);

  freeze_timer #(
    .W       (TW)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (tmr_start),
    .load    (tmr_load),
    .abort   (tmr_abort),
    .busy    (),
    .done    (tmr_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // Freeze actions, each on its own flop so none orders another

  logic freezing;
  assign freezing = (state_d == freeze_pkg::ST_ENTER) |
                    (state_d == freeze_pkg::ST_FROZEN);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_power_down <= 1'b1;
    end else begin
      pll_power_down <= freezing |
                        (state_d == freeze_pkg::ST_PWRUP);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_clk_en <= 1'b0;
    end else begin
      pll_clk_en <= (state_d == freeze_pkg::ST_RUN) |
                    (state_d == freeze_pkg::ST_EXIT);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_in_q <= 1'b0;
    end else begin
      force_in_q <= freezing;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_gl_q <= 1'b0;
    end else begin
      force_gl_q <= freezing;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_freeze_q <= 1'b0;
    end else begin
      pad_freeze_q <= freezing;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jtag_block <= 1'b1;
    end else begin
      // Still blocked during the exit settle
      jtag_block <= (state_d != freeze_pkg::ST_RUN);
    end
  end

  assign frozen = (state_q == freeze_pkg::ST_FROZEN);

  // Globals have no hold option
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      glob_core <= '1;
    end else begin
      glob_core <= force_gl_q ? '1 : glob_pad;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-pin cells

  for (genvar i = 0; i < N_IO; i++) begin : g_io
    freeze_io_cell u_cell (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .capture     (capture),
      .force_in    (force_in_q),
      .pad_freeze  (pad_freeze_q),
      .hold_in     (hold_in_q[i]),
      .hold_out    (hold_out_q[i]),
      .pull_en     (pull_en_q[i]),
      .pull_up     (pull_up_q[i]),
      .pad_in      (pad_in[i]),
      .pad_out     (pad_out[i]),
      .pad_oe      (pad_oe[i]),
      .pad_pull_en (pad_pull_en[i]),
      .pad_pull_up (pad_pull_up[i]),
      .core_out    (core_out[i]),
      .core_oe     (core_oe[i]),
      .core_in     (core_in[i])
    );
  end

endmodule // freeze_ctrl

// file: verif/freeze_ctrl_props.sv
/*
  Port checker for freeze_ctrl, bound into every instance.
  Assumes the single hclk domain and hresetn active low.
*/
`timescale 1ns/100ps
module freeze_ctrl_props #(
  parameter int N_IO = 8,
  parameter int N_GL = 2
) (
  // Clock and reset
  input wire logic            hclk,
  input wire logic            hresetn,
  // Freeze control
  input wire logic            supply_ok,
  input wire logic            freeze_request_pin,
  input wire logic            freeze_confirm_signal,
  input wire logic            pll_power_down,
  input wire logic            pll_clk_en,
  input wire logic            jtag_block,
  input wire logic            frozen,
  // Pads and globals
  input wire logic [N_IO-1:0] pad_oe,
  input wire logic [N_GL-1:0] glob_pad,
  input wire logic [N_GL-1:0] glob_core
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       cond;
  logic [4:0] ent_q;
  assign cond = supply_ok && freeze_request_pin && freeze_confirm_signal;
  // Cycles of held entry condition since taken from run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ent_q <= 5'h00;
    else if (!cond) ent_q <= 5'h00;
    else if ((!pll_power_down || ent_q != 5'h00) && ent_q != 5'h1f)
      ent_q <= ent_q + 5'h01;
  end
  ////////////////////////////////////////////////////////////
  AST_ENTRY_TIME: assert property (ent_q == 5'h14 |-> frozen)
    else $error("entry not done in 1 us");
  AST_EXIT_TIME: assert property (
    frozen && !freeze_request_pin && supply_ok |-> ##[1:20]
    (!jtag_block || freeze_request_pin || !supply_ok))
    else $error("exit not done in 1 us");
  AST_PLL_OFF: assert property (
    frozen |-> pll_power_down && !pll_clk_en && jtag_block)
    else $error("pll or scan active while frozen");
  AST_CLK_STOP: assert property (
    !pll_power_down && cond |=> !pll_clk_en)
    else $error("pll clocks kept after entry");
  AST_GLOB_HIGH: assert property (frozen |-> &glob_core)
    else $error("global not forced high");
  AST_PAD_TRI: assert property (frozen |-> pad_oe == '0)
    else $error("pad driven while frozen");
  AST_GLOB_PASS: assert property (
    !pll_power_down && !$past(pll_power_down) |->
    glob_core == $past(glob_pad))
    else $error("global not released in run");
  AST_SUPPLY_LOSS: assert property (
    !supply_ok [*2] |=> pll_power_down && !frozen)
    else $error("pll on without supply");
  cover property ($rose(frozen));
  cover property ($fell(frozen));
  cover property (ent_q == 5'h14);
endmodule // freeze_ctrl_props

bind freeze_ctrl freeze_ctrl_props #(.N_IO(N_IO), .N_GL(N_GL)) u_props (
  .hclk(hclk), .hresetn(hresetn), .supply_ok(supply_ok),
  .freeze_request_pin(freeze_request_pin),
  .freeze_confirm_signal(freeze_confirm_signal),
  .pll_power_down(pll_power_down), .pll_clk_en(pll_clk_en),
  .jtag_block(jtag_block), .frozen(frozen), .pad_oe(pad_oe),
  .glob_pad(glob_pad), .glob_core(glob_core));

// file: verif/freeze_host.sv
/*
  System controller and housekeeping model: request pin, confirm.
  Assumes hclk domain; the bench commands go, slow and drop.
*/
`timescale 1ns/100ps
module freeze_host (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Bench commands
  input  wire logic go,
  input  wire logic slow,
  input  wire logic drop,
  // Freeze link
  output logic      freeze_request_pin,
  output logic      freeze_confirm_signal
);
  logic [3:0] cnt_q;
  logic [3:0] dly;
  assign dly = slow ? 4'hc : 4'h1;
  // Request held for the whole stay; no test clock is driven at all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) freeze_request_pin <= 1'b0;
    else freeze_request_pin <= go;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_q <= 4'h0;
    else if (!freeze_request_pin) cnt_q <= 4'h0;
    else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
  end
  // Held through entry; drop lets it fall early, on command only
  assign freeze_confirm_signal = freeze_request_pin && cnt_q >= dly &&
    !(drop && cnt_q > dly + 4'h2);
endmodule // freeze_host

// file: verif/test_low_power_freeze_control.sv
/*
  Self-checking bench: registers, power-up entry, type 1 and 2
  entry, exit, hold and abort. Assumes freeze_host as partner.
*/
`timescale 1ns/100ps
`include "freeze_params.svh"
module test_low_power_freeze_control;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, glob_pad = 2'h0, glob_core;
  logic        supply_ok = 1'b0, go = 1'b0, slow = 1'b0, drop = 1'b0;
  logic        hreadyout, hresp, req, conf, frozen;
  logic        pll_power_down, pll_clk_en, jtag_block;
  logic [7:0]  pad_in = 8'h00, core_out = 8'h00, core_oe = 8'h00;
  logic [7:0]  pad_out, pad_oe, pad_pull_en, pad_pull_up, core_in, p, h;
  logic [7:0]  o, u;
  // Stand-in for the PLL acquisition wait after exit
  localparam int PLL_ACQ = 4;
  int          err_total = 0, comparisons = 0;

  initial forever #25 hclk = ~hclk;

  freeze_ctrl DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .supply_ok(supply_ok),
    .freeze_request_pin(req), .freeze_confirm_signal(conf),
    .pll_power_down(pll_power_down), .pll_clk_en(pll_clk_en),
    .jtag_block(jtag_block), .frozen(frozen), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pad_pull_up(pad_pull_up), .core_out(core_out), .core_oe(core_oe),
    .core_in(core_in), .glob_pad(glob_pad), .glob_core(glob_core));

  freeze_host u_host (
    .hclk(hclk), .hresetn(hresetn), .go(go), .slow(slow), .drop(drop),
    .freeze_request_pin(req), .freeze_confirm_signal(conf));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Bounded wait on frozen or on the scan block
  task automatic wait_on(input logic scan, input logic v, input int lim);
    int n;
    n = 0;
    comparisons++;
    while ((scan ? jtag_block : frozen) !== v) begin
      if (n == lim) begin
        err_total++;
        $display("unexpected at %0t: wait ran out", $time);
        final_report();
      end
      @(posedge hclk);
      n++;
    end
  endtask

  task automatic ready_wait();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 50) begin
        err_total++;
        $display("unexpected at %0t: bus hung", $time);
        final_report();
      end
    end while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    ready_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ready_wait();
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9efc));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(pll_power_down, 1'b1);
    chk(core_in, 8'hff);
    go <= 1'b1;
    repeat (30) @(posedge hclk);
    chk(frozen, 1'b0);
    supply_ok <= 1'b1;
    wait_on(1'b0, 1'b1, 100);
    chk(jtag_block, 1'b1);
    go <= 1'b0;
    wait_on(1'b1, 1'b0, 21);
    bus(1'b0, 8'h40, '0);
    chk(rd, 32'h0000_0000);
    bus(1'b0, `OFS_STATUS, '0);
    chk(rd, 32'h0000_0080);
    for (int t = 0; t < 2; t++) begin
      for (int i = 0; i < 4; i++) begin
        p = 8'($urandom);
        h = 8'($urandom);
        o = 8'($urandom);
        u = 8'($urandom);
        bus(1'b1, `OFS_CTRL, 32'(t));
        bus(1'b1, `OFS_HOLD_IN, {24'h00_0000, h});
        bus(1'b1, `OFS_PULL_EN, {24'h00_0000, ~h});
        bus(1'b1, `OFS_HOLD_OUT, {24'h00_0000, o});
        bus(1'b1, `OFS_PULL_UP, {24'h00_0000, u});
        bus(1'b0, `OFS_HOLD_IN, '0);
        chk(rd, {24'h00_0000, h});
        bus(1'b0, `OFS_PULL_UP, '0);
        chk(rd, {24'h00_0000, u});
        pad_in <= p;
        glob_pad <= 2'($urandom);
        core_out <= 8'($urandom);
        core_oe <= 8'($urandom);
        slow <= 1'($urandom);
        @(posedge hclk);
        go <= 1'b1;
        wait_on(1'b0, 1'b1, 22 + (t == 1 ? (slow ? 12 : 1) : 0));
        pad_in <= ~p;
        repeat (3) @(posedge hclk);
        chk(core_in, 8'((p & h) | ~h));
        chk(glob_core, 2'h3);
        chk(pad_oe, 8'h00);
        chk(pad_pull_en, 8'(o | ~h));
        chk(pad_pull_up, 8'((o & core_out) | (~o & u)));
        chk(pll_clk_en, 1'b0);
        chk(pll_power_down, 1'b1);
        go <= 1'b0;
        wait_on(1'b1, 1'b0, 21);
        repeat (PLL_ACQ) @(posedge hclk);
        chk(pll_clk_en, 1'b1);
        chk(pll_power_down, 1'b0);
        chk(core_in, 8'(~p));
        chk(pad_out, core_out);
        chk(pad_oe, core_oe);
      end
    end
    // Confirm falls early: entry must not complete
    drop <= 1'b1;
    go <= 1'b1;
    repeat (40) begin
      @(posedge hclk);
      chk(frozen, 1'b0);
    end
    go <= 1'b0;
    drop <= 1'b0;
    repeat (20) @(posedge hclk);
    final_report();
  end
endmodule // test_low_power_freeze_control
